/* src/brd_regs.svh */
// Register offsets, field positions, reset values and timing counts for the board glue block
`ifndef BRD_REGS_SVH
`define BRD_REGS_SVH

// ==========================================================
// Register byte offsets
`define BRD_OFF_CTRL      32'h0000_0000
`define BRD_OFF_STAT      32'h0000_0004
`define BRD_OFF_CMD       32'h0000_0008
`define BRD_OFF_RXDATA    32'h0000_000c
`define BRD_OFF_ISTAT     32'h0000_0010
`define BRD_OFF_IMASK     32'h0000_0014

// ==========================================================
// Control register fields
`define BRD_CTRL_SCL      0
`define BRD_CTRL_SDA      1
`define BRD_CTRL_LED      2
`define BRD_CTRL_RESET    32'h0000_0007

// ==========================================================
// Status register fields
`define BRD_STAT_SDA_IN   0
`define BRD_STAT_BATT     1
`define BRD_STAT_BUSY     2
`define BRD_STAT_LED_DRIVE_PIN     3

// ==========================================================
// Command register fields
`define BRD_CMD_START     8
`define BRD_CMD_STOP      9
`define BRD_CMD_WRITE     10
`define BRD_CMD_READ      11
`define BRD_CMD_LED_DRIVE_PIN      12

// ==========================================================
// Interrupt status and mask fields
`define BRD_INT_DONE      0
`define BRD_INT_LED_DRIVE_PIN      1
`define BRD_INT_BATT_LOW  2
`define BRD_INT_BITS      3

// ==========================================================
// Serial clock timing
`define BRD_CLK_MHZ       50
`define BRD_SCL_HALF_NS   5000
`define BRD_SCL_HALF_CYC  ((`BRD_SCL_HALF_NS * `BRD_CLK_MHZ) / 1000)

`endif

/* src/brd_pkg.sv */
// Types shared by the board glue block
package brd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START_A,
    ST_START_B,
    ST_BIT_LOW,
    ST_BIT_HIGH,
    ST_STOP_A,
    ST_STOP_B,
    ST_STOP_C
  } brd_state_e;

  typedef struct packed {
    logic [31:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } brd_apb_req_s;

  typedef struct packed {
    logic sda_in;
    logic batt_ok;
  } brd_pins_s;

endpackage

/* src/brd_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module brd_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* src/brd_glue.sv */
// Board glue: two-wire EEPROM engine, battery status, activity LED, APB registers
//
// Function
// - Data returned by the EEPROM is read only on the dedicated data input pin.
// - Data toward the EEPROM is driven only on the dedicated data output pin.
// - Logic 0 is a low level near 0V and logic 1 a high level near 5V on every pin.
// - The battery input reads 0 at or below 2,265 V (discharged) and 1 above (charged).
// - Driving the LED pin to 0 lights the LED and driving it to 1 turns it off.
// - After reset the LED pin is 1 so the LED starts off.
`timescale 1ns/1ps
`include "brd_regs.svh"
module brd_glue (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire brd_pkg::brd_apb_req_s apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic                  eeprom_data_in_pin,
  output logic                       eeprom_data_out_pin,
  output logic                       eeprom_scl_pin,
  input  wire logic                  battery_ok_pin,
  output logic                       led_drive_pin,
  output logic                       irq
);
  import brd_pkg::*;

  localparam logic [8:0] HALF_CYC = 9'(`BRD_SCL_HALF_CYC);

  // ==========================================================
  // Input synchronisers
  brd_pins_s pins_sync;

  brd_sync #(.WIDTH(2)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({eeprom_data_in_pin, battery_ok_pin}),
    .sync_out (pins_sync)
  );

  // ==========================================================
  // APB slave, one wait state so read data comes from a flop
  logic        ack_reg;
  logic        wr_en;
  logic        addr_ok;
  logic [31:0] ctrl_reg;
  logic [31:0] imask_reg;
  logic [`BRD_INT_BITS-1:0] istat_reg;
  logic [7:0]  shift_reg;
  logic        led_drive_pin_reg;
  brd_state_e  state_reg;

  function automatic logic brd_addr_hit(input logic [31:0] a, input logic [31:0] off);
    brd_addr_hit = (a == off);
  endfunction

  assign addr_ok = brd_addr_hit(apb_req.paddr, `BRD_OFF_CTRL)
                 | brd_addr_hit(apb_req.paddr, `BRD_OFF_STAT)
                 | brd_addr_hit(apb_req.paddr, `BRD_OFF_CMD)
                 | brd_addr_hit(apb_req.paddr, `BRD_OFF_RXDATA)
                 | brd_addr_hit(apb_req.paddr, `BRD_OFF_ISTAT)
                 | brd_addr_hit(apb_req.paddr, `BRD_OFF_IMASK);
  assign pready  = ack_reg;
  assign pslverr = ack_reg & ~addr_ok;
  assign wr_en   = psel & penable & ack_reg & apb_req.pwrite & addr_ok;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= psel & penable & ~ack_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & penable & ~ack_reg & ~apb_req.pwrite) begin
      prdata <= 32'h0000_0000;
      if (brd_addr_hit(apb_req.paddr, `BRD_OFF_CTRL)) begin
        prdata <= ctrl_reg;
      end
      if (brd_addr_hit(apb_req.paddr, `BRD_OFF_STAT)) begin
        prdata[`BRD_STAT_SDA_IN] <= pins_sync.sda_in;
        prdata[`BRD_STAT_BATT]   <= pins_sync.batt_ok;
        prdata[`BRD_STAT_BUSY]   <= (state_reg != ST_IDLE);
        prdata[`BRD_STAT_LED_DRIVE_PIN]   <= led_drive_pin_reg;
      end
      if (brd_addr_hit(apb_req.paddr, `BRD_OFF_RXDATA)) begin
        prdata[7:0] <= shift_reg;
      end
      if (brd_addr_hit(apb_req.paddr, `BRD_OFF_ISTAT)) begin
        prdata[`BRD_INT_BITS-1:0] <= istat_reg;
      end
      if (brd_addr_hit(apb_req.paddr, `BRD_OFF_IMASK)) begin
        prdata <= imask_reg;
      end
    end
  end

  // ==========================================================
  // Control and mask registers
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= `BRD_CTRL_RESET;
    end else if (wr_en && brd_addr_hit(apb_req.paddr, `BRD_OFF_CTRL)) begin
      ctrl_reg <= {29'h0000_0000, apb_req.pwdata[2:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      imask_reg <= 32'h0000_0000;
    end else if (wr_en && brd_addr_hit(apb_req.paddr, `BRD_OFF_IMASK)) begin
      imask_reg <= {29'h0000_0000, apb_req.pwdata[`BRD_INT_BITS-1:0]};
    end
  end

  // LED pin is active low, off after reset
  assign led_drive_pin = ctrl_reg[`BRD_CTRL_LED];

  // ==========================================================
  // Byte engine
  logic       cmd_wr;
  logic       tick;
  logic [8:0] div_cnt;
  logic [3:0] bit_cnt;
  logic       rd_mode;
  logic       led_drive_pin_cfg;
  logic       ev_done;

  assign cmd_wr = wr_en && brd_addr_hit(apb_req.paddr, `BRD_OFF_CMD) && (state_reg == ST_IDLE);
  assign tick   = (state_reg != ST_IDLE) && (div_cnt == HALF_CYC - 9'h001);

  // Bit to place on the data line; release for read data and for the slave's ack
  function automatic logic brd_drive_bit(input logic rd, input logic [3:0] idx,
                                         input logic msb, input logic nk);
    if (idx == 4'h8) begin
      brd_drive_bit = rd ? nk : 1'b1;
    end else begin
      brd_drive_bit = rd ? 1'b1 : msb;
    end
  endfunction

  always_ff @(posedge clock) begin
    if (rst || state_reg == ST_IDLE || tick) begin
      div_cnt <= 9'h000;
    end else begin
      div_cnt <= div_cnt + 9'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else if (cmd_wr) begin
      if (apb_req.pwdata[`BRD_CMD_START]) begin
        state_reg <= ST_START_A;
      end else if (apb_req.pwdata[`BRD_CMD_STOP]) begin
        state_reg <= ST_STOP_A;
      end else if (apb_req.pwdata[`BRD_CMD_WRITE] | apb_req.pwdata[`BRD_CMD_READ]) begin
        state_reg <= ST_BIT_LOW;
      end
    end else if (tick) begin
      case (state_reg)
        ST_START_A:  state_reg <= ST_START_B;
        ST_START_B:  state_reg <= ST_IDLE;
        ST_BIT_LOW:  state_reg <= ST_BIT_HIGH;
        ST_BIT_HIGH: state_reg <= (bit_cnt == 4'h8) ? ST_IDLE : ST_BIT_LOW;
        ST_STOP_A:   state_reg <= ST_STOP_B;
        ST_STOP_B:   state_reg <= ST_STOP_C;
        ST_STOP_C:   state_reg <= ST_IDLE;
        default:     state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bit_cnt   <= 4'h0;
      rd_mode   <= 1'b0;
      led_drive_pin_cfg  <= 1'b0;
      shift_reg <= 8'h00;
      led_drive_pin_reg  <= 1'b0;
    end else if (cmd_wr) begin
      bit_cnt   <= 4'h0;
      rd_mode   <= apb_req.pwdata[`BRD_CMD_READ] & ~apb_req.pwdata[`BRD_CMD_WRITE];
      led_drive_pin_cfg  <= apb_req.pwdata[`BRD_CMD_LED_DRIVE_PIN];
      shift_reg <= apb_req.pwdata[7:0];
    end else if (tick && state_reg == ST_BIT_HIGH) begin
      // Sample at the end of the high phase, data is settled by then
      if (bit_cnt == 4'h8) begin
        led_drive_pin_reg <= pins_sync.sda_in;
      end else begin
        shift_reg <= {shift_reg[6:0], pins_sync.sda_in};
        bit_cnt   <= bit_cnt + 4'h1;
      end
    end
  end

  // ==========================================================
  // Pin drivers: engine owns the pins while busy, software otherwise
  always_ff @(posedge clock) begin
    if (rst) begin
      eeprom_scl_pin      <= 1'b1;
      eeprom_data_out_pin <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      if (cmd_wr && (apb_req.pwdata[`BRD_CMD_WRITE] | apb_req.pwdata[`BRD_CMD_READ])
          && !apb_req.pwdata[`BRD_CMD_START] && !apb_req.pwdata[`BRD_CMD_STOP]) begin
        eeprom_scl_pin      <= 1'b0;
        eeprom_data_out_pin <= brd_drive_bit(apb_req.pwdata[`BRD_CMD_READ]
                                             & ~apb_req.pwdata[`BRD_CMD_WRITE], 4'h0,
                                             apb_req.pwdata[7], apb_req.pwdata[`BRD_CMD_LED_DRIVE_PIN]);
      end else if (cmd_wr && apb_req.pwdata[`BRD_CMD_STOP]
                   && !apb_req.pwdata[`BRD_CMD_START]) begin
        eeprom_scl_pin      <= 1'b0;
        eeprom_data_out_pin <= 1'b0;
      end else if (!cmd_wr && wr_en && brd_addr_hit(apb_req.paddr, `BRD_OFF_CTRL)) begin
        eeprom_scl_pin      <= apb_req.pwdata[`BRD_CTRL_SCL];
        eeprom_data_out_pin <= apb_req.pwdata[`BRD_CTRL_SDA];
      end
    end else if (tick) begin
      case (state_reg)
        ST_START_A: eeprom_data_out_pin <= 1'b0;
        ST_START_B: eeprom_scl_pin      <= 1'b0;
        ST_BIT_LOW: eeprom_scl_pin      <= 1'b1;
        ST_BIT_HIGH: begin
          eeprom_scl_pin <= 1'b0;
          if (bit_cnt != 4'h8) begin
            eeprom_data_out_pin <= brd_drive_bit(rd_mode, bit_cnt + 4'h1, shift_reg[6], led_drive_pin_cfg);
          end
        end
        ST_STOP_A:  eeprom_scl_pin      <= 1'b1;
        ST_STOP_B:  eeprom_data_out_pin <= 1'b1;
        default:    eeprom_scl_pin      <= eeprom_scl_pin;
      endcase
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear, a new event wins
  logic batt_prev;
  logic [`BRD_INT_BITS-1:0] ev_vec;
  logic [`BRD_INT_BITS-1:0] clr_vec;

  assign ev_done = tick && ((state_reg == ST_START_B) || (state_reg == ST_STOP_C)
                   || (state_reg == ST_BIT_HIGH && bit_cnt == 4'h8));
  assign ev_vec  = {batt_prev & ~pins_sync.batt_ok,
                    ev_done & (state_reg == ST_BIT_HIGH) & pins_sync.sda_in & ~rd_mode,
                    ev_done};
  assign clr_vec = (wr_en && brd_addr_hit(apb_req.paddr, `BRD_OFF_ISTAT))
                   ? apb_req.pwdata[`BRD_INT_BITS-1:0] : '0;

  always_ff @(posedge clock) begin
    if (rst) begin
      batt_prev <= 1'b1;
      istat_reg <= '0;
    end else begin
      batt_prev <= pins_sync.batt_ok;
      istat_reg <= (istat_reg & ~clr_vec) | ev_vec;
    end
  end

  assign irq = |(istat_reg & imask_reg[`BRD_INT_BITS-1:0]);

  // ==========================================================
  // Checks
  led_reset_off_a: assert property (@(posedge clock) rst |=> led_drive_pin)
    else $error("LED pin not off after reset");
  led_follow_a: assert property (@(posedge clock) disable iff (rst)
    wr_en && brd_addr_hit(apb_req.paddr, `BRD_OFF_CTRL)
    |=> led_drive_pin == $past(apb_req.pwdata[`BRD_CTRL_LED]))
    else $error("LED pin does not follow control write");
  read_release_a: assert property (@(posedge clock) disable iff (rst)
    state_reg == ST_BIT_HIGH && rd_mode && bit_cnt != 4'h8 |-> eeprom_data_out_pin)
    else $error("Data line not released during read");
  sample_high_a: assert property (@(posedge clock) disable iff (rst)
    tick && state_reg == ST_BIT_HIGH |-> eeprom_scl_pin)
    else $error("Data sampled while clock low");
  batt_path_a: assert property (@(posedge clock) disable iff (rst)
    ##2 pins_sync.batt_ok == $past(battery_ok_pin, 2))
    else $error("Battery status not two stages behind pin");
  start_cond_a: assert property (@(posedge clock) disable iff (rst)
    state_reg == ST_START_A && tick |=> !eeprom_data_out_pin && eeprom_scl_pin)
    else $error("Start condition malformed");
  clock_high_hold_a: assert property (@(posedge clock) disable iff (rst)
    $rose(eeprom_scl_pin) && state_reg == ST_BIT_HIGH |=> eeprom_scl_pin [*8])
    else $error("Serial clock high phase too short");
  led_drive_pin_irq_a: assert property (@(posedge clock) disable iff (rst)
    ev_vec[`BRD_INT_LED_DRIVE_PIN] && imask_reg[`BRD_INT_LED_DRIVE_PIN] |=> irq)
    else $error("Unmasked no-ack did not raise interrupt");
  byte_done_c: cover property (@(posedge clock) disable iff (rst)
    ev_done && state_reg == ST_BIT_HIGH);
  stop_done_c: cover property (@(posedge clock) disable iff (rst)
    tick && state_reg == ST_STOP_C);
  batt_low_c: cover property (@(posedge clock) disable iff (rst) ev_vec[`BRD_INT_BATT_LOW]);

endmodule

/* verification/brd_eeprom_model.sv */
// Behavioural serial EEPROM seen through the split data pins and the clock pin
`timescale 1ns/1ps
module brd_eeprom_model #(
  parameter logic [6:0] DEV_ADDR  = 7'h50,
  parameter logic [7:0] READ_BYTE = 8'hc3
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_master,
  output logic            sda_bus,
  output logic [7:0]      last_byte
);
  logic       scl_q, sda_q, act, first, sel, rd, pull;
  logic [3:0] cnt;
  logic [7:0] sh, rdb;

  // ==========================================================
  // Wired line
  // Pull-up: a released line reads high, never the last value
  assign sda_bus = sda_master & ~pull;

  // ==========================================================
  // Bit engine
  always_ff @(posedge clock) begin
    scl_q <= scl;
    sda_q <= sda_master;
    if (rst) begin
      act <= 1'b0;
      pull <= 1'b0;
      cnt <= 4'h0;
      last_byte <= 8'h00;
    end else if (scl && scl_q && sda_q && !sda_master) begin
      act <= 1'b1;
      first <= 1'b1;
      sel <= 1'b0;
      cnt <= 4'h0;
      pull <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda_master) begin
      act <= 1'b0;
      pull <= 1'b0;
    end else if (act && scl && !scl_q) begin
      // Sample while clock is high, bits arrive first to last from the top
      if (cnt < 4'h8) sh <= {sh[6:0], sda_bus};
      cnt <= cnt + 4'h1;
    end else if (act && !scl && scl_q) begin
      if (cnt == 4'h8) begin
        last_byte <= sh;
        if (first) begin
          sel <= (sh[7:1] == DEV_ADDR);
          rd <= sh[0];
          pull <= (sh[7:1] == DEV_ADDR);
        end else begin
          pull <= sel & ~rd;
        end
      end else if (cnt == 4'h9) begin
        cnt <= 4'h0;
        first <= 1'b0;
        pull <= sel & rd & ~READ_BYTE[7];
        rdb <= {READ_BYTE[6:0], 1'b1};
      end else if (cnt != 4'h0 && sel && rd && !first) begin
        pull <= ~rdb[7];
        rdb <= {rdb[6:0], 1'b1};
      end
    end
  end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the board glue block
`timescale 1ns/1ps
`include "brd_regs.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  bad_count++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
  import brd_pkg::*;
  localparam logic [7:0]  RD_BYTE = 8'hc3;
  localparam logic [6:0]  DEV     = 7'h50;
  localparam logic [31:0] CS      = 32'h1 << `BRD_CMD_START;
  localparam logic [31:0] CP      = 32'h1 << `BRD_CMD_STOP;
  localparam logic [31:0] CW      = 32'h1 << `BRD_CMD_WRITE;
  localparam logic [31:0] CR      = 32'h1 << `BRD_CMD_READ;
  localparam logic [31:0] CN      = 32'h1 << `BRD_CMD_LED_DRIVE_PIN;
  logic         clock, rst, psel, penable, pready, pslverr, err;
  logic         sda_out, scl, batt, led, irq, sda_in, b;
  brd_apb_req_s req;
  logic [31:0]  prdata, rd, ist;
  logic [7:0]   last_byte, wdb;
  logic [2:0]   v;
  int           bad_count, total_checks;

  always #10 clock = ~clock;

  brd_glue i_dut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .apb_req(req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .eeprom_data_in_pin(sda_in),
    .eeprom_data_out_pin(sda_out), .eeprom_scl_pin(scl), .battery_ok_pin(batt),
    .led_drive_pin(led), .irq(irq));

  brd_eeprom_model #(.DEV_ADDR(DEV), .READ_BYTE(RD_BYTE)) i_mem (
    .clock(clock), .rst(rst), .scl(scl), .sda_master(sda_out), .sda_bus(sda_in),
    .last_byte(last_byte));

  // ==========================================================
  // Bus tasks
  // Missing ack expected whenever the address is not ours
  function automatic logic exp_led_drive_pin(input logic [6:0] a);
    exp_led_drive_pin = (a != DEV);
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    req <= '{paddr: a, pwrite: wr, pwdata: d};
    @(posedge clock);
    penable <= 1'b1;
    // Ready, read data and error are taken only at a rising edge
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      bad_count++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Issue one link command and wait for busy to drop
  task automatic cmd(input logic [31:0] c);
    int n;
    n = 0;
    apb(1'b1, `BRD_OFF_CMD, c);
    do begin
      apb(1'b0, `BRD_OFF_STAT, 32'h0);
      n++;
    end while (rd[`BRD_STAT_BUSY] !== 1'b0 && n < 3000);
    if (rd[`BRD_STAT_BUSY] !== 1'b0) begin
      bad_count++;
      test_done();
    end
    `CHK("irq_done", 1'b1, irq)
    apb(1'b0, `BRD_OFF_ISTAT, 32'h0);
    ist = rd;
    apb(1'b1, `BRD_OFF_ISTAT, 32'h3);
    `CHK("irq_clr", 1'b0, irq)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    req = '0;
    batt = 1'b1;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(34));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    `CHK("led_rst", 1'b1, led)
    `CHK("scl_rst", 1'b1, scl)
    `CHK("sda_rst", 1'b1, sda_out)
    apb(1'b0, `BRD_OFF_CTRL, 32'h0);
    `CHK("ctrl_rst", `BRD_CTRL_RESET, rd)
    // Bit-banged pins, all-low corner first
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 3'b000 : 3'($urandom);
      apb(1'b1, `BRD_OFF_CTRL, {29'h0, v});
      `CHK("scl", v[0], scl)
      `CHK("sda_out", v[1], sda_out)
      `CHK("led", v[2], led)
      apb(1'b0, `BRD_OFF_STAT, 32'h0);
      `CHK("stat_sda", v[1], rd[`BRD_STAT_SDA_IN])
    end
    // Battery always fitted here, so the status is never don't-care
    for (int i = 0; i < 6; i++) begin
      b = 1'($urandom);
      batt <= b;
      repeat (4) @(posedge clock);
      apb(1'b0, `BRD_OFF_STAT, 32'h0);
      `CHK("batt", b, rd[`BRD_STAT_BATT])
    end
    // Battery drop: masked, unmasked, cleared
    batt <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b1, `BRD_OFF_ISTAT, 32'h7);
    batt <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, `BRD_OFF_IMASK, 32'h7);
    `CHK("irq_batt", 1'b1, irq)
    apb(1'b0, `BRD_OFF_ISTAT, 32'h0);
    `CHK("istat_batt", 3'b100, rd[2:0])
    apb(1'b1, `BRD_OFF_ISTAT, 32'h4);
    `CHK("irq_w1c", 1'b0, irq)
    batt <= 1'b1;
    apb(1'b0, 32'h18, 32'h0);
    `CHK("slverr", 1'b1, err)
    apb(1'b1, `BRD_OFF_CTRL, 32'h7);
    // Addressed write of one data byte
    cmd(CS);
    cmd(CW | {DEV, 1'b0});
    `CHK("addr_ack", exp_led_drive_pin(DEV), ist[`BRD_INT_LED_DRIVE_PIN])
    wdb = 8'd32 + 8'($urandom % 224);
    cmd(CW | wdb);
    `CHK("byte_out", wdb, last_byte)
    `CHK("data_ack", 1'b0, ist[`BRD_INT_LED_DRIVE_PIN])
    cmd(CP);
    `CHK("scl_idle", 1'b1, scl)
    `CHK("sda_idle", 1'b1, sda_out)
    // Wrong strap bits: nobody answers
    cmd(CS);
    cmd(CW | {DEV ^ 7'h1, 1'b0});
    `CHK("addr_led_drive_pin", exp_led_drive_pin(DEV ^ 7'h1), ist[`BRD_INT_LED_DRIVE_PIN])
    apb(1'b0, `BRD_OFF_STAT, 32'h0);
    `CHK("stat_led_drive_pin", 1'b1, rd[`BRD_STAT_LED_DRIVE_PIN])
    cmd(CP);
    // Read two bytes, acknowledge the first and refuse more
    cmd(CS);
    cmd(CW | {DEV, 1'b1});
    // First byte acknowledged by the master, so the memory sends another
    cmd(CR);
    apb(1'b0, `BRD_OFF_RXDATA, 32'h0);
    `CHK("rx_ack_byte", RD_BYTE, rd[7:0])
    apb(1'b0, `BRD_OFF_STAT, 32'h0);
    `CHK("stat_master_ack", 1'b0, rd[`BRD_STAT_LED_DRIVE_PIN])
    cmd(CR | CN);
    apb(1'b0, `BRD_OFF_RXDATA, 32'h0);
    `CHK("rx_byte", RD_BYTE, rd[7:0])
    cmd(CP);
    test_done();
  end
endmodule
